// ---- design/cpc_pkg.sv ----
package cpc_pkg;

    // register offsets, as printed
    localparam logic [7:0] OFS_WD_CTRL = 8'h01;
    localparam logic [7:0] OFS_PRE_TERM = 8'h03;
    localparam logic [7:0] OFS_VLIMIT = 8'h04;
    localparam logic [7:0] OFS_TIMING = 8'h05;
    localparam logic [7:0] OFS_INPROT = 8'h06;

    // reset values
    localparam logic [7:0] RST_PRE_TERM = 8'hAA;
    localparam logic [7:0] RST_VLIMIT = 8'h58;
    localparam logic [7:0] RST_TIMING = 8'hBF;
    localparam logic [7:0] RST_INPROT = 8'hE6;
    localparam logic [7:0] RD_ZERO = 8'h00;

    // field positions
    localparam int RESTART_BIT = 6;
    localparam int PRE_LSB = 4;
    localparam int TERM_LSB = 0;
    localparam int VCODE_LSB = 3;
    localparam int TOPOFF_LSB = 1;
    localparam int RECH_BIT = 0;
    localparam int TERM_EN_BIT = 7;
    localparam int DEG_SEL_BIT = 6;
    localparam int WD_LSB = 4;
    localparam int SAFE_EN_BIT = 3;
    localparam int SAFE_DUR_BIT = 2;
    localparam int THERMAL_REG_THRESHOLD_BIT = 1;
    localparam int COLD_SEL_BIT = 0;
    localparam int OVP_LSB = 6;
    localparam int BOOST_LSB = 4;
    localparam int VIN_LSB = 0;

    // charge voltage decode
    localparam logic [4:0] VCODE_MAX = 5'h18;
    localparam logic [4:0] VCODE_SPECIAL = 5'h0F;
    localparam logic [12:0] V_BASE_MV = 13'h0F10;
    localparam logic [12:0] V_SPECIAL_MV = 13'h10FE;
    localparam logic [12:0] V_CLAMP_MV = 13'h1210;
    localparam logic [12:0] RECH_LO_MV = 13'h0064;
    localparam logic [12:0] RECH_HI_MV = 13'h00C8;

    // other decoded settings
    localparam logic [5:0] TOPOFF_STEP_MIN = 6'h0F;
    localparam logic [7:0] WD_40_S = 8'h28;
    localparam logic [7:0] WD_80_S = 8'h50;
    localparam logic [7:0] WD_160_S = 8'hA0;
    localparam logic [4:0] SAFE_SHORT_H = 5'h07;
    localparam logic [4:0] SAFE_LONG_H = 5'h10;
    localparam logic [6:0] THERMAL_REG_THRESHOLD_LO_C = 7'h50;
    localparam logic [6:0] THERMAL_REG_THRESHOLD_HI_C = 7'h78;
    localparam logic [6:0] COLD_HALF_PCT = 7'h32;
    localparam logic [6:0] COLD_FIFTH_PCT = 7'h14;
    localparam logic [6:0] COLD_FULL_PCT = 7'h64;
    localparam logic [13:0] OVP_0_MV = 14'h157C;
    localparam logic [13:0] OVP_1_MV = 14'h1964;
    localparam logic [13:0] OVP_2_MV = 14'h2904;
    localparam logic [13:0] OVP_3_MV = 14'h36B0;
    localparam logic [12:0] BOOST_0_MV = 13'h12F2;
    localparam logic [12:0] BOOST_STEP_MV = 13'h0096;
    localparam logic [13:0] VIN_OS_0_MV = 14'h0F3C;
    localparam logic [13:0] VIN_OS_1_MV = 14'h170C;
    localparam logic [13:0] VIN_OS_2_MV = 14'h1D4C;
    localparam logic [13:0] VIN_OS_3_MV = 14'h2904;
    localparam logic [13:0] VIN_STEP_MV = 14'h0064;

    // timing
    localparam int CLK_KHZ = 50000;
    localparam int TERM_LONG_MS = 230;
    localparam int TERM_SHORT_MS = 16;
    localparam int SEC_MS = 1000;
    localparam int TERM_LONG_CYC = TERM_LONG_MS * CLK_KHZ;
    localparam int TERM_SHORT_CYC = TERM_SHORT_MS * CLK_KHZ;
    localparam int SEC_CYC = SEC_MS * CLK_KHZ;

    typedef struct packed {
        logic [7:0] precharge_ma;
        logic [7:0] term_ma;
        logic [12:0] charge_mv;
        logic [12:0] recharge_mv;
        logic [5:0] topoff_min;
        logic term_enable;
        logic [7:0] wd_period_s;
        logic safety_enable;
        logic [4:0] safety_hours;
        logic [6:0] thermal_c;
        logic [6:0] cold_pct;
        logic [13:0] ovp_mv;
        logic [12:0] boost_mv;
        logic [13:0] vin_reg_mv;
    } cpc_cfg_type;

    typedef enum logic [1:0] {
        DG_IDLE = 2'b00,
        DG_FILT = 2'b01,
        DG_HELD = 2'b11
    } cpc_dg_state_type;

    // shared step table of pre-charge and termination currents
    function automatic logic [7:0] current_ma(input logic [3:0] code);
        logic [7:0] ma;
        ma = 8'h00;
        unique case (code)
            4'h0: ma = 8'h05;
            4'h1: ma = 8'h0A;
            4'h2: ma = 8'h0F;
            4'h3: ma = 8'h14;
            4'h4: ma = 8'h1E;
            4'h5: ma = 8'h28;
            4'h6: ma = 8'h32;
            4'h7: ma = 8'h3C;
            4'h8: ma = 8'h50;
            4'h9: ma = 8'h64;
            4'hA: ma = 8'h78;
            4'hB: ma = 8'h8C;
            4'hC: ma = 8'hA0;
            4'hD: ma = 8'hB4;
            4'hE: ma = 8'hC8;
            4'hF: ma = 8'hF0;
        endcase
        return ma;
    endfunction : current_ma

endpackage : cpc_pkg

// ---- design/cpc_regs.sv ----
`timescale 1ns/1ps
// What this block does
// - pre-charge current code in bits 7:4, sixteen-step table, reset 1010
// - termination current code in bits 3:0, same table, reset 1010
// - charge voltage 3856 + 32n mV, code 15 gives 4350 mV
// - charge voltage codes above 24 act as 24, 4624 mV
// - top-off period 00 off, then 15, 30, 45 minutes
// - recharge threshold is voltage limit minus 100 or 200 mV
// - termination allowed only while enable bit 7 is set
// - termination condition filtered 230 ms or 16 ms before acting
// - watchdog period 00 off, 40, 80, 160 s; restart prevents expiry
// - safety timer enable covers pre-charge and fast-charge phases
// - safety timer limit 7 h or 16 h
// - thermal regulation threshold 80 or 120 degrees C
// - cold band current cut to 50% or 20% when enabled
// - input over-voltage 5.5, 6.5, 10.5, 14 V; register reset only
// - boost output 4.85, 5.00, 5.15, 5.30 V
// - input regulation threshold is offset plus 0.1 V per code step
module cpc_regs #(
    parameter int SEC_CYCLES = cpc_pkg::SEC_CYC,
    parameter int DEG_LONG_CYCLES = cpc_pkg::TERM_LONG_CYC,
    parameter int DEG_SHORT_CYCLES = cpc_pkg::TERM_SHORT_CYC
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic term_cond_i,
    input wire logic cold_current_enable_i,
    input wire logic [1:0] input_voltage_reg_offset_i,
    output cpc_pkg::cpc_cfg_type cfg_o,
    output logic term_done_o,
    output logic wd_expired_o
);

    localparam int CNT_W = 24;
    localparam int SEC_W = 26;

    // a one-cycle filter would leave the filter state with no dwell
    if (SEC_CYCLES < 1 || SEC_CYCLES >= 2**SEC_W ||
        DEG_LONG_CYCLES < 2 || DEG_LONG_CYCLES >= 2**CNT_W ||
        DEG_SHORT_CYCLES < 2 || DEG_SHORT_CYCLES >= 2**CNT_W) begin : g_bad
        $error("cpc_regs: count parameter out of range");
    end

    localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SEC_CYCLES - 1);
    localparam logic [CNT_W-1:0] DEG_LONG_LAST = CNT_W'(DEG_LONG_CYCLES - 1);
    localparam logic [CNT_W-1:0] DEG_SHORT_LAST =
        CNT_W'(DEG_SHORT_CYCLES - 1);

    // register file
    logic [7:0] pre_term_ff, vlimit_ff, timing_ff, inprot_ff;
    logic [7:0] nxt_pre_term, nxt_vlimit, nxt_timing, nxt_inprot;
    logic restart_ff, nxt_restart;
    logic [7:0] rdata_ff, nxt_rdata;
    // watchdog
    logic [SEC_W-1:0] tick_cnt_ff, nxt_tick_cnt;
    logic [7:0] sec_cnt_ff, nxt_sec_cnt;
    logic expire_ff, nxt_expire;
    logic wd_expire;
    logic [7:0] wd_period;
    // deglitch
    logic cond_meta_ff, cond_sync_ff;
    cpc_pkg::cpc_dg_state_type dg_state_ff;
    cpc_pkg::cpc_dg_state_type nxt_dg_state;
    logic [CNT_W-1:0] dg_cnt_ff, nxt_dg_cnt;
    logic term_done_ff, nxt_term_done;
    cpc_pkg::cpc_cfg_type cfg_ff, nxt_cfg;

    logic wr_restart;
    assign wr_restart = reg_wr_i && reg_addr_i == cpc_pkg::OFS_WD_CTRL &&
        reg_wdata_i[cpc_pkg::RESTART_BIT];

    always_comb begin
        case (timing_ff[cpc_pkg::WD_LSB +: 2])
            2'b01: wd_period = cpc_pkg::WD_40_S;
            2'b10: wd_period = cpc_pkg::WD_80_S;
            2'b11: wd_period = cpc_pkg::WD_160_S;
            default: wd_period = 8'h00;
        endcase
    end

    // a shortened period expires at the next second, never wraps around
    assign wd_expire = wd_period != 8'h00 && !restart_ff &&
        tick_cnt_ff == SEC_LAST && sec_cnt_ff >= wd_period - 8'h01;

    always_comb begin
        nxt_pre_term = pre_term_ff;
        nxt_vlimit = vlimit_ff;
        nxt_timing = timing_ff;
        nxt_inprot = inprot_ff;
        nxt_restart = restart_ff;
        nxt_rdata = rdata_ff;
        nxt_tick_cnt = tick_cnt_ff + SEC_W'(1);
        nxt_sec_cnt = sec_cnt_ff;
        nxt_expire = wd_expire;
        if (tick_cnt_ff == SEC_LAST) begin
            nxt_tick_cnt = '0;
            nxt_sec_cnt = sec_cnt_ff + 8'h01;
        end
        if (restart_ff || wd_period == 8'h00 || wd_expire) begin
            nxt_tick_cnt = '0;
            nxt_sec_cnt = 8'h00;
            nxt_restart = 1'b0;
        end
        if (wd_expire) begin
            // the input protection register survives expiry
            nxt_pre_term = cpc_pkg::RST_PRE_TERM;
            nxt_vlimit = cpc_pkg::RST_VLIMIT;
            nxt_timing = cpc_pkg::RST_TIMING;
        end
        // a host write lands after expiry restore, so it is not lost
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                cpc_pkg::OFS_PRE_TERM: nxt_pre_term = reg_wdata_i;
                cpc_pkg::OFS_VLIMIT: nxt_vlimit = reg_wdata_i;
                cpc_pkg::OFS_TIMING: nxt_timing = reg_wdata_i;
                cpc_pkg::OFS_INPROT: nxt_inprot = reg_wdata_i;
                default: ;
            endcase
        end
        if (wr_restart) begin
            nxt_restart = 1'b1;
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                cpc_pkg::OFS_WD_CTRL:
                    nxt_rdata = 8'(restart_ff) << cpc_pkg::RESTART_BIT;
                cpc_pkg::OFS_PRE_TERM: nxt_rdata = pre_term_ff;
                cpc_pkg::OFS_VLIMIT: nxt_rdata = vlimit_ff;
                cpc_pkg::OFS_TIMING: nxt_rdata = timing_ff;
                cpc_pkg::OFS_INPROT: nxt_rdata = inprot_ff;
                default: nxt_rdata = cpc_pkg::RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pre_term_ff <= cpc_pkg::RST_PRE_TERM;
            vlimit_ff <= cpc_pkg::RST_VLIMIT;
            timing_ff <= cpc_pkg::RST_TIMING;
            inprot_ff <= cpc_pkg::RST_INPROT;
            restart_ff <= 1'b0;
            rdata_ff <= cpc_pkg::RD_ZERO;
            tick_cnt_ff <= '0;
            sec_cnt_ff <= 8'h00;
            expire_ff <= 1'b0;
        end else if (ce_i) begin
            pre_term_ff <= nxt_pre_term;
            vlimit_ff <= nxt_vlimit;
            timing_ff <= nxt_timing;
            inprot_ff <= nxt_inprot;
            restart_ff <= nxt_restart;
            rdata_ff <= nxt_rdata;
            tick_cnt_ff <= nxt_tick_cnt;
            sec_cnt_ff <= nxt_sec_cnt;
            expire_ff <= nxt_expire;
        end
    end

    // decoded settings
    logic [4:0] vcode;
    assign vcode = vlimit_ff[cpc_pkg::VCODE_LSB +: 5];

    always_comb begin
        nxt_cfg.precharge_ma =
            cpc_pkg::current_ma(pre_term_ff[cpc_pkg::PRE_LSB +: 4]);
        nxt_cfg.term_ma =
            cpc_pkg::current_ma(pre_term_ff[cpc_pkg::TERM_LSB +: 4]);
        if (vcode > cpc_pkg::VCODE_MAX) begin
            nxt_cfg.charge_mv = cpc_pkg::V_CLAMP_MV;
        end else if (vcode == cpc_pkg::VCODE_SPECIAL) begin
            nxt_cfg.charge_mv = cpc_pkg::V_SPECIAL_MV;
        end else begin
            nxt_cfg.charge_mv = cpc_pkg::V_BASE_MV + {3'b000, vcode, 5'h00};
        end
        nxt_cfg.recharge_mv = nxt_cfg.charge_mv -
            (vlimit_ff[cpc_pkg::RECH_BIT] ? cpc_pkg::RECH_HI_MV
                                          : cpc_pkg::RECH_LO_MV);
        nxt_cfg.topoff_min = 6'(vlimit_ff[cpc_pkg::TOPOFF_LSB +: 2] *
            cpc_pkg::TOPOFF_STEP_MIN);
        nxt_cfg.term_enable = timing_ff[cpc_pkg::TERM_EN_BIT];
        nxt_cfg.wd_period_s = wd_period;
        nxt_cfg.safety_enable = timing_ff[cpc_pkg::SAFE_EN_BIT];
        nxt_cfg.safety_hours = timing_ff[cpc_pkg::SAFE_DUR_BIT] ?
            cpc_pkg::SAFE_LONG_H : cpc_pkg::SAFE_SHORT_H;
        nxt_cfg.thermal_c = timing_ff[cpc_pkg::THERMAL_REG_THRESHOLD_BIT] ?
            cpc_pkg::THERMAL_REG_THRESHOLD_HI_C : cpc_pkg::THERMAL_REG_THRESHOLD_LO_C;
        if (!cold_current_enable_i) begin
            nxt_cfg.cold_pct = cpc_pkg::COLD_FULL_PCT;
        end else begin
            nxt_cfg.cold_pct = timing_ff[cpc_pkg::COLD_SEL_BIT] ?
                cpc_pkg::COLD_FIFTH_PCT : cpc_pkg::COLD_HALF_PCT;
        end
        unique case (inprot_ff[cpc_pkg::OVP_LSB +: 2])
            2'b00: nxt_cfg.ovp_mv = cpc_pkg::OVP_0_MV;
            2'b01: nxt_cfg.ovp_mv = cpc_pkg::OVP_1_MV;
            2'b10: nxt_cfg.ovp_mv = cpc_pkg::OVP_2_MV;
            2'b11: nxt_cfg.ovp_mv = cpc_pkg::OVP_3_MV;
        endcase
        nxt_cfg.boost_mv = cpc_pkg::BOOST_0_MV + 13'(
            inprot_ff[cpc_pkg::BOOST_LSB +: 2] * cpc_pkg::BOOST_STEP_MV);
        unique case (input_voltage_reg_offset_i)
            2'b00: nxt_cfg.vin_reg_mv = cpc_pkg::VIN_OS_0_MV;
            2'b01: nxt_cfg.vin_reg_mv = cpc_pkg::VIN_OS_1_MV;
            2'b10: nxt_cfg.vin_reg_mv = cpc_pkg::VIN_OS_2_MV;
            2'b11: nxt_cfg.vin_reg_mv = cpc_pkg::VIN_OS_3_MV;
        endcase
        nxt_cfg.vin_reg_mv = nxt_cfg.vin_reg_mv + 14'(
            inprot_ff[cpc_pkg::VIN_LSB +: 4] * cpc_pkg::VIN_STEP_MV);
    end

    // termination deglitch; a drop of the condition restarts the filter
    logic [CNT_W-1:0] dg_last;
    assign dg_last = timing_ff[cpc_pkg::DEG_SEL_BIT] ? DEG_SHORT_LAST
                                                     : DEG_LONG_LAST;

    always_comb begin
        nxt_dg_state = dg_state_ff;
        nxt_dg_cnt = dg_cnt_ff;
        unique case (dg_state_ff)
            cpc_pkg::DG_IDLE: begin
                nxt_dg_cnt = '0;
                if (cond_sync_ff) begin
                    nxt_dg_state = cpc_pkg::DG_FILT;
                end
            end
            cpc_pkg::DG_FILT: begin
                nxt_dg_cnt = dg_cnt_ff + CNT_W'(1);
                if (!cond_sync_ff) begin
                    nxt_dg_state = cpc_pkg::DG_IDLE;
                end else if (dg_cnt_ff >= dg_last) begin
                    nxt_dg_state = cpc_pkg::DG_HELD;
                end
            end
            cpc_pkg::DG_HELD: begin
                if (!cond_sync_ff) begin
                    nxt_dg_state = cpc_pkg::DG_IDLE;
                end
            end
            default: nxt_dg_state = cpc_pkg::DG_IDLE;
        endcase
        nxt_term_done = dg_state_ff == cpc_pkg::DG_HELD &&
            timing_ff[cpc_pkg::TERM_EN_BIT];
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cond_meta_ff <= 1'b0;
            cond_sync_ff <= 1'b0;
            dg_state_ff <= cpc_pkg::DG_IDLE;
            dg_cnt_ff <= '0;
            term_done_ff <= 1'b0;
            cfg_ff <= '0;
        end else if (ce_i) begin
            cond_meta_ff <= term_cond_i;
            cond_sync_ff <= cond_meta_ff;
            dg_state_ff <= nxt_dg_state;
            dg_cnt_ff <= nxt_dg_cnt;
            term_done_ff <= nxt_term_done;
            cfg_ff <= nxt_cfg;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign cfg_o = cfg_ff;
    assign term_done_o = term_done_ff;
    assign wd_expired_o = expire_ff;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    sequence s_expire;
        ce_i && wd_expire && !reg_wr_i;
    endsequence
    sequence s_restored;
        pre_term_ff == cpc_pkg::RST_PRE_TERM &&
        vlimit_ff == cpc_pkg::RST_VLIMIT &&
        timing_ff == cpc_pkg::RST_TIMING && inprot_ff == $past(inprot_ff);
    endsequence

    AST_PRE_TABLE: assert property (
        ce_i && pre_term_ff[cpc_pkg::PRE_LSB +: 4] == 4'hA
        |=> cfg_ff.precharge_ma == 8'h78)
        else $error("precharge decode wrong");
    AST_TERM_TABLE: assert property (
        ce_i && pre_term_ff[cpc_pkg::TERM_LSB +: 4] == 4'hF
        |=> cfg_ff.term_ma == 8'hF0)
        else $error("termination decode wrong");
    AST_VSPECIAL: assert property (
        ce_i && vcode == 5'h0F |=> cfg_ff.charge_mv == 13'h10FE)
        else $error("special voltage code wrong");
    AST_VCLAMP: assert property (
        ce_i && vcode > 5'h18 |=> cfg_ff.charge_mv == 13'h1210)
        else $error("voltage clamp wrong");
    AST_RECHARGE: assert property (
        ce_i && vlimit_ff[cpc_pkg::RECH_BIT]
        |=> cfg_ff.charge_mv - cfg_ff.recharge_mv == 13'h00C8)
        else $error("recharge offset wrong");
    AST_TERM_GATE: assert property (
        ce_i && !timing_ff[cpc_pkg::TERM_EN_BIT] |=> !term_done_o)
        else $error("termination while disabled");
    AST_DEGLITCH: assert property (
        ce_i && dg_state_ff == cpc_pkg::DG_IDLE ##1 ce_i && cond_sync_ff
        |=> dg_state_ff != cpc_pkg::DG_HELD)
        else $error("deglitch skipped filter");
    AST_RESTART_CLEAR: assert property (
        ce_i && restart_ff && !wr_restart |=> !restart_ff)
        else $error("restart bit not cleared");
    AST_EXPIRE_RESTORE: assert property (
        s_expire |=> s_restored ##0 wd_expired_o)
        else $error("expiry restore wrong");

endmodule : cpc_regs

// ---- design/cpc_regs_fix.sv ----
`timescale 1ns/1ps

// ---- dv/cpc_host_model.sv ----
`timescale 1ns/1ps
module cpc_host_model (
    input wire logic core_clk_i,
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i
);
    int gap = 0;
    bit busy = 1'b0;

    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end

    // idle bus churns so a stale address never passes for a held one
    always @(negedge core_clk_i) begin
        if (!busy) begin
            reg_addr_o <= ~reg_addr_o;
            reg_wdata_o <= ~reg_wdata_o;
        end
    end

    // one strobe cycle per request; gap makes the host slow
    task automatic xfer(input logic [7:0] a, input logic wr,
                        input logic [7:0] d, output logic [7:0] q);
        busy = 1'b1;
        repeat (gap + 1) @(negedge core_clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = wr;
        reg_rd_o = !wr;
        @(negedge core_clk_i);
        q = reg_rdata_i;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        busy = 1'b0;
    endtask : xfer

    task automatic kick();
        logic [7:0] q;
        xfer(cpc_pkg::OFS_WD_CTRL, 1'b1, 8'h40, q);
    endtask : kick
endmodule : cpc_host_model

// ---- dv/test_charge_parameter_config_regs.sv ----
`timescale 1ns/1ps
module test_charge_parameter_config_regs;
    localparam int LONG = 20;
    localparam int SHORT = 5;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic term_cond = 1'b0;
    logic cold_en = 1'b0;
    logic [1:0] vin_os = 2'b00;
    logic [7:0] addr, wdata, rdata;
    logic reg_wr, reg_rd, term_done, wd_exp;
    cpc_pkg::cpc_cfg_type cfg;
    logic [7:0] m [8];
    int fails = 0;
    int n_tests = 0;
    int n_wd = 0;
    int cur_tab [16] = '{5, 10, 15, 20, 30, 40, 50, 60,
                         80, 100, 120, 140, 160, 180, 200, 240};
    int ovp_tab [4] = '{5500, 6500, 10500, 14000};
    int os_tab [4] = '{3900, 5900, 7500, 10500};
    int wd_tab [4] = '{0, 40, 80, 160};

    always #10 clk = ~clk;

    // pulse counted where it stands settled, away from its launch edge
    always @(negedge clk) begin
        if (wd_exp === 1'b1) n_wd++;
    end

    cpc_regs #(.SEC_CYCLES(4), .DEG_LONG_CYCLES(LONG),
               .DEG_SHORT_CYCLES(SHORT)) u_cpc_regs (
        .core_clk_i(clk), .srst_i(srst), .ce_i(ce),
        .reg_addr_i(addr), .reg_wr_i(reg_wr), .reg_wdata_i(wdata),
        .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .term_cond_i(term_cond),
        .cold_current_enable_i(cold_en),
        .input_voltage_reg_offset_i(vin_os), .cfg_o(cfg),
        .term_done_o(term_done), .wd_expired_o(wd_exp)
    );

    cpc_host_model u_host (
        .core_clk_i(clk), .reg_addr_o(addr), .reg_wr_o(reg_wr),
        .reg_wdata_o(wdata), .reg_rd_o(reg_rd), .reg_rdata_i(rdata)
    );

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %0h seen %0h",
                     name, exp, seen);
        end
    endtask : check

    task automatic do_reset();
        srst = 1'b1;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        m = '{8'h00, 8'h00, 8'h00, 8'hAA, 8'h58, 8'hBF, 8'hE6, 8'h00};
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_host.xfer(a, 1'b1, d, q);
        if (ce && a >= 8'h03 && a <= 8'h06) m[a[2:0]] = d;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a);
        logic [7:0] q, e;
        u_host.xfer(a, 1'b0, 8'h00, q);
        e = (a >= 8'h03 && a <= 8'h06) ? m[a[2:0]] : 8'h00;
        check("rdata", q, e);
    endtask : rd_chk

    task automatic rd_all();
        for (int a = 0; a < 8; a++) rd_chk(a[7:0]);
    endtask : rd_all

    // decoded settings worked out from the model's register images
    task automatic chk_cfg();
        int n, v, c, w;
        repeat (2) @(negedge clk);
        n = m[4][7:3] > 24 ? 24 : m[4][7:3];
        v = n == 15 ? 4350 : 3856 + 32 * n;
        check("pre_ma", cfg.precharge_ma, cur_tab[m[3][7:4]]);
        check("term_ma", cfg.term_ma, cur_tab[m[3][3:0]]);
        check("chg_mv", cfg.charge_mv, v);
        check("rech_mv", cfg.recharge_mv, v - (m[4][0] ? 200 : 100));
        check("topoff", cfg.topoff_min, 15 * m[4][2:1]);
        check("term_en", cfg.term_enable, m[5][7]);
        check("wd_s", cfg.wd_period_s, wd_tab[m[5][5:4]]);
        check("safe_en", cfg.safety_enable, m[5][3]);
        check("safe_h", cfg.safety_hours, m[5][2] ? 16 : 7);
        check("thermal_reg_threshold", cfg.thermal_c, m[5][1] ? 120 : 80);
        c = !cold_en ? 100 : m[5][0] ? 20 : 50;
        check("cold", cfg.cold_pct, c);
        check("ovp", cfg.ovp_mv, ovp_tab[m[6][7:6]]);
        check("boost", cfg.boost_mv, 4850 + 150 * m[6][5:4]);
        w = os_tab[vin_os] + 100 * m[6][3:0];
        check("vin", cfg.vin_reg_mv, w);
    endtask : chk_cfg

    task automatic term_run(input int n_exp, input logic en);
        int k;
        term_cond = 1'b1;
        for (k = 0; k < n_exp + 12 && term_done !== 1'b1; k++)
            @(negedge clk);
        if (en) check("term_lat", k >= n_exp && k <= n_exp + 7, 1);
        else check("term_off", term_done, 1'b0);
        term_cond = 1'b0;
        repeat (6) @(negedge clk);
        check("term_drop", term_done, 1'b0);
    endtask : term_run

    initial begin
        logic [7:0] r;
        int k;
        void'($urandom(72308));
        do_reset();
        rd_all();
        chk_cfg();
        for (int i = 0; i < 16; i++) begin
            u_host.kick();
            wr(8'h03, {i[3:0], ~i[3:0]});
            rd_chk(8'h03);
            chk_cfg();
        end
        for (int i = 0; i < 32; i++) begin
            u_host.kick();
            r = 8'($urandom);
            wr(8'h04, {i[4:0], r[2:0]});
            chk_cfg();
        end
        for (int i = 0; i < 8; i++) begin
            u_host.kick();
            cold_en = 1'($urandom);
            r = 8'($urandom);
            r[5:4] = i[1:0];
            wr(8'h05, r);
            chk_cfg();
        end
        for (int i = 0; i < 16; i++) begin
            u_host.kick();
            u_host.gap = i % 3;
            vin_os = 2'($urandom);
            r = 8'($urandom);
            wr(8'h06, {i[1:0], i[3:2], r[3:0]});
            chk_cfg();
        end
        u_host.gap = 0;
        u_host.kick();
        wr(8'h07, 8'hFF);
        ce = 1'b0;
        wr(8'h03, 8'h00);
        ce = 1'b1;
        rd_all();
        // termination filter, glitch first so the restart shows
        u_host.kick();
        wr(8'h05, 8'h8F);
        term_cond = 1'b1;
        repeat (LONG - 5) @(negedge clk);
        term_cond = 1'b0;
        repeat (4) @(negedge clk);
        term_run(LONG, 1'b1);
        wr(8'h05, 8'hCF);
        term_run(SHORT, 1'b1);
        wr(8'h05, 8'h4F);
        term_run(SHORT, 1'b0);
        // watchdog: kicked in time, then left to expire
        wr(8'h03, 8'h12);
        wr(8'h04, 8'h01);
        wr(8'h06, 8'h1B);
        u_host.kick();
        wr(8'h05, 8'h9F);
        for (int i = 0; i < 4; i++) begin
            repeat (100) @(negedge clk);
            u_host.kick();
        end
        check("wd_early", n_wd, 0);
        rd_chk(8'h01);
        for (k = 0; k < 200 && wd_exp !== 1'b1; k++) @(negedge clk);
        check("wd_lat", k >= 150 && k <= 170, 1);
        m[3] = 8'hAA;
        m[4] = 8'h58;
        m[5] = 8'hBF;
        repeat (3) @(negedge clk);
        check("wd_pulse", n_wd, 1);
        rd_all();
        chk_cfg();
        wr(8'h05, 8'h8F);
        repeat (700) @(negedge clk);
        check("wd_off", n_wd, 1);
        do_reset();
        rd_all();
        chk_cfg();
        stop_test();
    end
endmodule : test_charge_parameter_config_regs
